// ===== logic/lcd_mcu_parallel_host_port.sv
// parallel microcontroller port of the display controller
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
module lcd_mcu_parallel_host_port (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // straps
   input wire logic ifaceStrapHi,
   input wire logic widthStrapMid,
   input wire logic widthStrapLo,
   input wire logic protocolSelectStrap,
   // host control pins
   input wire logic chipSelN,
   input wire logic extResetN,
   input wire logic writeStrobeN,
   input wire logic readStrobeN,
   input wire logic cmdDataFlag,
   // host data lanes
   input wire logic [17:0] dataIn,
   output logic [17:0] dataOut,
   output logic [17:0] dataOeN,
   // core write side
   output logic wrValid,
   output logic wrIsCmd,
   output logic [17:0] wrWord,
   // core read side
   input wire logic [17:0] rdWord,
   input wire logic rdWordIsPixel,
   output logic rdStart,
   output logic rdDone,
   // mode view
   output logic serialMode,
   output logic enableMode,
   output logic [1:0] widthCode,
   // serial lanes toward a serial engine
   input wire logic serialSdaOut,
   input wire logic serialSdaOeN,
   output logic serialClk,
   output logic serialSdaIn,
   output logic serialDcFlag
);

   logic [4:0] ctlLevel;
   logic [4:0] ctlRise;
   logic [4:0] ctlFall;
   logic [17:0] dataLevel;
   logic intRst;
   logic csActive;
   logic wrEvt;
   logic rdStartEvt;
   logic rdEndEvt;
   logic [17:0] widthMask;
   logic [17:0] rdMask;
   logic serialMode_r;
   logic enableMode_r;
   logic [1:0] widthCode_r;
   logic wrValid_r;
   logic wrIsCmd_r;
   logic [17:0] wrWord_r;
   logic rdStart_r;
   logic rdDone_r;
   logic [17:0] dataOut_r;
   logic [17:0] dataOeN_r;
   logic serialClk_r;
   logic serialSdaIn_r;
   logic serialDcFlag_r;
   lcd_port_pkg::port_state_e state_r;
   lcd_port_pkg::port_state_e state_nxt;

   // strobes are free-running async pins, so each is synchronised
   sync_edge #(
      .W(lcd_port_pkg::CG_W)
   ) u_ctlSync (
      .clk(clk),
      .rst(rst),
      .pinIn({extResetN, cmdDataFlag, readStrobeN, writeStrobeN,
         chipSelN}),
      .level(ctlLevel),
      .rise(ctlRise),
      .fall(ctlFall)
   );

   // data delayed by the same depth so it lines up with the strobe edge
   sync_edge #(
      .W(lcd_port_pkg::BUS_W)
   ) u_dataSync (
      .clk(clk),
      .rst(rst),
      .pinIn(dataIn),
      .level(dataLevel),
      .rise(),
      .fall()
   );

   // external reset clears the port like the system reset
   assign intRst = rst | ~ctlLevel[lcd_port_pkg::CG_XRST];
   assign csActive = ~ctlLevel[lcd_port_pkg::CG_CS];

   // straps held while in reset, frozen afterwards
   always_ff @(posedge clk)
   begin
      if (intRst)
      begin
         serialMode_r <= ~ifaceStrapHi;
         enableMode_r <= ifaceStrapHi & protocolSelectStrap;
         widthCode_r <= {widthStrapMid, widthStrapLo};
      end
   end

   // lanes in use for the selected width
   always_comb
   begin
      case (widthCode_r)
         lcd_port_pkg::WCODE_8: widthMask = lcd_port_pkg::MASK_8;
         lcd_port_pkg::WCODE_16: widthMask = lcd_port_pkg::MASK_16;
         lcd_port_pkg::WCODE_9: widthMask = lcd_port_pkg::MASK_9;
         lcd_port_pkg::WCODE_18: widthMask = lcd_port_pkg::MASK_18;
         default: widthMask = lcd_port_pkg::MASK_8;
      endcase
   end

   // pixel reads full width, parameter and status reads 8 bits
   assign rdMask = rdWordIsPixel ? widthMask : lcd_port_pkg::MASK_8;

   // transfer events, all gated by chip select
   always_comb
   begin
      wrEvt = 1'b0;
      rdStartEvt = 1'b0;
      if (!serialMode_r && csActive)
      begin
         if (!enableMode_r)
         begin
            // data taken on write strobe rising edge
            wrEvt = ctlRise[lcd_port_pkg::CG_WR];
            rdStartEvt = ctlFall[lcd_port_pkg::CG_RD];
         end
         else
         begin
            // read pin is enable, write pin is direction
            wrEvt = ctlFall[lcd_port_pkg::CG_RD]
               & ~ctlLevel[lcd_port_pkg::CG_WR];
            rdStartEvt = ctlRise[lcd_port_pkg::CG_RD]
               & ctlLevel[lcd_port_pkg::CG_WR];
         end
      end
   end

   // read ends on the host's sampling edge or on chip select release
   assign rdEndEvt = !csActive ? 1'b1
      : enableMode_r ? ctlFall[lcd_port_pkg::CG_RD]
      : ctlRise[lcd_port_pkg::CG_RD];

   // read phase tracking
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         lcd_port_pkg::IDLE:
         begin
            if (rdStartEvt)
            begin
               state_nxt = lcd_port_pkg::READING;
            end
         end
         lcd_port_pkg::READING:
         begin
            if (rdEndEvt)
            begin
               state_nxt = lcd_port_pkg::IDLE;
            end
         end
         default: state_nxt = lcd_port_pkg::IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (intRst)
      begin
         state_r <= lcd_port_pkg::IDLE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // write capture
   always_ff @(posedge clk)
   begin
      if (intRst)
      begin
         wrValid_r <= 1'b0;
         wrIsCmd_r <= 1'b0;
         wrWord_r <= lcd_port_pkg::DATA_ZERO;
      end
      else
      begin
         wrValid_r <= wrEvt;
         if (wrEvt)
         begin
            // flag low marks a command
            wrIsCmd_r <= ~ctlLevel[lcd_port_pkg::CG_DC];
            if (!ctlLevel[lcd_port_pkg::CG_DC])
            begin
               wrWord_r <= dataLevel & lcd_port_pkg::MASK_8;
            end
            else
            begin
               // data words keep every lane of the selected width
               wrWord_r <= dataLevel & widthMask;
            end
         end
      end
   end

   // read handshake pulses to the core
   always_ff @(posedge clk)
   begin
      if (intRst)
      begin
         rdStart_r <= 1'b0;
         rdDone_r <= 1'b0;
      end
      else
      begin
         rdStart_r <= (state_r == lcd_port_pkg::IDLE) & rdStartEvt;
         rdDone_r <= (state_r == lcd_port_pkg::READING) & rdEndEvt;
      end
   end

   // lane drivers; serial engine owns lane 0 in serial mode
   always_ff @(posedge clk)
   begin
      if (intRst)
      begin
         dataOut_r <= lcd_port_pkg::DATA_ZERO;
         dataOeN_r <= lcd_port_pkg::LANES_OFF;
      end
      else if (serialMode_r)
      begin
         dataOut_r <= {17'h00000, serialSdaOut};
         dataOeN_r <= {17'h1FFFF, serialSdaOeN};
      end
      else if (state_r == lcd_port_pkg::IDLE && rdStartEvt)
      begin
         // word frozen at read start so lanes stay stable
         dataOut_r <= rdWord & rdMask;
         dataOeN_r <= ~rdMask;
      end
      else if (state_r == lcd_port_pkg::READING && rdEndEvt)
      begin
         dataOeN_r <= lcd_port_pkg::LANES_OFF;
      end
      else if (state_r == lcd_port_pkg::IDLE)
      begin
         dataOeN_r <= lcd_port_pkg::LANES_OFF;
      end
   end

   // serial pin view: cmd/data pin clocks, write pin flags
   always_ff @(posedge clk)
   begin
      if (intRst)
      begin
         serialClk_r <= 1'b0;
         serialSdaIn_r <= 1'b0;
         serialDcFlag_r <= 1'b0;
      end
      else
      begin
         serialClk_r <= serialMode_r & ctlLevel[lcd_port_pkg::CG_DC];
         serialSdaIn_r <= serialMode_r & dataLevel[0];
         serialDcFlag_r <= serialMode_r & ctlLevel[lcd_port_pkg::CG_WR];
      end
   end

   assign dataOut = dataOut_r;
   assign dataOeN = dataOeN_r;
   assign wrValid = wrValid_r;
   assign wrIsCmd = wrIsCmd_r;
   assign wrWord = wrWord_r;
   assign rdStart = rdStart_r;
   assign rdDone = rdDone_r;
   assign serialMode = serialMode_r;
   assign enableMode = enableMode_r;
   assign widthCode = widthCode_r;
   assign serialClk = serialClk_r;
   assign serialSdaIn = serialSdaIn_r;
   assign serialDcFlag = serialDcFlag_r;

   default clocking cbChk @(posedge clk);
   endclocking
   default disable iff (intRst);

   chk_serial_upper_off: assert property (
      serialMode_r |-> (dataOeN_r[17:1] == 17'h1FFFF) && !wrValid_r)
      else $error("serial mode drives upper lanes or writes");

   chk_narrow_lanes: assert property (
      wrValid_r && widthCode_r == lcd_port_pkg::WCODE_8
      |-> wrWord_r[17:8] == 10'h000)
      else $error("upper lanes leaked in narrow width");

   chk_cs_gates: assert property (
      wrValid_r |-> $past(csActive))
      else $error("write taken without chip select");

   chk_wr_rise: assert property (
      wrValid_r && !enableMode_r
      |-> $past(ctlRise[lcd_port_pkg::CG_WR]))
      else $error("write not on write strobe rise");

   chk_cmd_low_byte: assert property (
      wrValid_r && wrIsCmd_r |-> wrWord_r[17:8] == 10'h000)
      else $error("command word wider than 8 bits");

   chk_param_read8: assert property (
      !serialMode_r && $fell(dataOeN_r[0]) && !$past(rdWordIsPixel)
      |-> dataOeN_r[17:8] == 10'h3FF)
      else $error("parameter read drives upper lanes");

   chk_enable_fall: assert property (
      wrValid_r && enableMode_r
      |-> $past(ctlFall[lcd_port_pkg::CG_RD])
         && !$past(ctlLevel[lcd_port_pkg::CG_WR]))
      else $error("enable write not on enable fall");

   chk_read_release: assert property (
      !serialMode_r && state_r == lcd_port_pkg::READING && !csActive
      |=> dataOeN_r == lcd_port_pkg::LANES_OFF)
      else $error("lanes not released on chip select high");

   chk_read_drive: assert property (
      !serialMode_r && state_r == lcd_port_pkg::IDLE && rdStartEvt
      |=> rdStart_r && state_r == lcd_port_pkg::READING
         ##1 dataOeN_r == ~$past(rdMask, 2) || !csActive
         || state_r == lcd_port_pkg::IDLE)
      else $error("read data not driven after read start");

endmodule

// ===== logic/lcd_port_pkg.sv
// constants and types shared by the parallel host port
package lcd_port_pkg;

   // data lanes
   localparam int BUS_W = 18;
   localparam int CMD_W = 8;

   // width strap codes {width_strap_mid, width_strap_lo}
   localparam logic [1:0] WCODE_8 = 2'h0;
   localparam logic [1:0] WCODE_16 = 2'h1;
   localparam logic [1:0] WCODE_9 = 2'h2;
   localparam logic [1:0] WCODE_18 = 2'h3;

   // lane masks per width
   localparam logic [17:0] MASK_8 = 18'h000FF;
   localparam logic [17:0] MASK_9 = 18'h001FF;
   localparam logic [17:0] MASK_16 = 18'h0FFFF;
   localparam logic [17:0] MASK_18 = 18'h3FFFF;

   // protocol strap values
   localparam logic PROTO_SEPARATE = 1'h0;
   localparam logic PROTO_ENABLE = 1'h1;

   // reset values
   localparam logic [17:0] LANES_OFF = 18'h3FFFF;
   localparam logic [17:0] DATA_ZERO = 18'h00000;

   // control group bit positions into the synchroniser
   localparam int CG_W = 5;
   localparam int CG_CS = 0;
   localparam int CG_WR = 1;
   localparam int CG_RD = 2;
   localparam int CG_DC = 3;
   localparam int CG_XRST = 4;
   localparam logic [4:0] CG_IDLE = 5'h1F;

   // synchroniser depth before the edge stage
   localparam int SYNC_STAGES = 2;

   typedef enum logic {IDLE, READING} port_state_e;

endpackage

// ===== logic/sync_edge.sv
// two-flop synchroniser with edge detect for a group of pins
`timescale 1ns/10ps
module sync_edge #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // asynchronous pins
   input wire logic [W-1:0] pinIn,
   // synchronised view
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);

   logic [W-1:0] meta_r;
   logic [W-1:0] stable_r;
   logic [W-1:0] prev_r;

   // stages run through reset so they hold the pin levels at release;
   // a strobe that idles low then shows no false edge afterwards
   always_ff @(posedge clk)
   begin
      meta_r <= pinIn;
      stable_r <= meta_r; // first stage read only by the second
      prev_r <= stable_r;
   end

   assign level = stable_r;
   // reset must last three edges to flush the stages
   assign rise = stable_r & ~prev_r & ~{W{rst}};
   assign fall = ~stable_r & prev_r & ~{W{rst}};

endmodule

// ===== bench/lcd_host_model.sv
// host microcontroller model driving the parallel port pins
`timescale 1ns/10ps
module lcd_host_model (
   // clock
   input wire logic clk,
   // host set-up from the bench
   input wire logic enMode,
   input wire logic useCs,
   // device lane drive
   input wire logic [17:0] dataOut,
   input wire logic [17:0] dataOeN,
   // host pins
   output logic chipSelN,
   output logic writeStrobeN,
   output logic readStrobeN,
   output logic cmdDataFlag,
   output logic [17:0] dataIn
);
   logic [17:0] hostDrv = 18'h00000;
   logic [17:0] lastLane = 18'h00000;
   logic hostOn = 1'h0;

   initial
   begin
      chipSelN = 1'h1;
      writeStrobeN = 1'h1;
      readStrobeN = 1'h1;
      cmdDataFlag = 1'h1;
   end

   // floating lanes flip each cycle so stale data never passes as read data
   always_comb
   begin
      for (int i = 0; i < 18; i++)
      begin
         if (!dataOeN[i])
            dataIn[i] = dataOut[i];
         else if (hostOn)
            dataIn[i] = hostDrv[i];
         else
            dataIn[i] = ~lastLane[i];
      end
   end

   always @(posedge clk)
      lastLane <= dataIn;

   // idle strobe level: high for separate, low for enable
   task automatic park();
      readStrobeN <= !enMode;
   endtask

   task automatic pins(input logic dc, input logic wr, input logic d0);
      cmdDataFlag <= dc;
      writeStrobeN <= wr;
      hostDrv <= {17'h0, d0};
      hostOn <= 1'h1;
   endtask

   // 3-cycle set-up and hold phases around a 5-cycle strobe phase stay clear of the 3-cycle synchroniser
   task automatic xfer(input logic rd, input logic dc,
      input logic [17:0] d, output logic [17:0] q);
      @(posedge clk);
      chipSelN <= !useCs;
      cmdDataFlag <= dc;
      hostDrv <= d;
      hostOn <= !rd;
      writeStrobeN <= enMode ? rd : 1'h1;
      repeat (3) @(posedge clk);
      if (enMode)
         readStrobeN <= 1'h1;
      else if (rd)
         readStrobeN <= 1'h0;
      else
         writeStrobeN <= 1'h0;
      repeat (5) @(posedge clk);
      q = dataIn;
      readStrobeN <= !enMode;
      writeStrobeN <= enMode ? rd : 1'h1;
      repeat (3) @(posedge clk);
      chipSelN <= 1'h1;
      hostOn <= 1'h0;
   endtask

   // read cut short: chip select released while the strobe is active
   task automatic cutRead();
      @(posedge clk);
      chipSelN <= 1'h0;
      hostOn <= 1'h0;
      writeStrobeN <= 1'h1;
      repeat (3) @(posedge clk);
      readStrobeN <= enMode;
      repeat (5) @(posedge clk);
      chipSelN <= 1'h1;
      repeat (5) @(posedge clk);
      readStrobeN <= !enMode;
   endtask
endmodule

// ===== bench/lcd_mcu_parallel_host_port_tb.sv
// self-checking bench for the parallel host port
`timescale 1ns/10ps
module lcd_mcu_parallel_host_port_tb;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic extResetN = 1'h1;
   logic [3:0] straps = 4'h8;
   logic enMode = 1'h0;
   logic useCs = 1'h1;
   logic [17:0] rdWord = 18'h00000;
   logic rdWordIsPixel = 1'h0;
   logic chipSelN, writeStrobeN, readStrobeN, cmdDataFlag;
   logic [17:0] dataIn, dataOut, dataOeN, wrWord, oeSeen, gotWord, q, mask;
   logic wrValid, wrIsCmd, rdStart, rdDone, serialMode, enableMode, gotCmd;
   logic serialClk, serialSdaIn, serialDcFlag;
   logic [1:0] widthCode;
   logic sdaOut = 1'h0;
   logic sdaOeN = 1'h1;
   int wrCount = 0;
   int failCount = 0;
   int checked = 0;
   int base;
   int doneBase;
   int doneCount = 0;
   logic [7:0] codes [3] = '{8'hDB, 8'h04, 8'h09};
   logic [17:0] masks [4] = '{18'h000FF, 18'h0FFFF, 18'h001FF, 18'h3FFFF};

   always #2.5 clk = ~clk;

   lcd_mcu_parallel_host_port DUT (.clk, .rst,
      .ifaceStrapHi(straps[3]), .protocolSelectStrap(straps[2]),
      .widthStrapMid(straps[1]), .widthStrapLo(straps[0]),
      .chipSelN, .extResetN, .writeStrobeN, .readStrobeN, .cmdDataFlag,
      .dataIn, .dataOut, .dataOeN, .wrValid, .wrIsCmd, .wrWord,
      .rdWord, .rdWordIsPixel, .rdStart, .rdDone,
      .serialMode, .enableMode, .widthCode,
      .serialSdaOut(sdaOut), .serialSdaOeN(sdaOeN),
      .serialClk, .serialSdaIn, .serialDcFlag);

   lcd_host_model HOST (.clk, .enMode, .useCs, .dataOut, .dataOeN,
      .chipSelN, .writeStrobeN, .readStrobeN, .cmdDataFlag, .dataIn);

   always @(posedge clk)
   begin
      if (wrValid === 1'h1)
      begin
         wrCount <= wrCount + 1;
         gotWord <= wrWord;
         gotCmd <= wrIsCmd;
      end
      if (rdStart === 1'h1)
         oeSeen <= dataOeN;
      if (rdDone === 1'h1)
         doneCount <= doneCount + 1;
   end

   task automatic chk(input string what, input logic [17:0] exp,
      input logic [17:0] got);
      checked++;
      if (got !== exp)
      begin
         failCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic printVerdict();
      $display("checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // answers land 3 cycles after the pins, so settle before looking
   task automatic xf(input logic rd, input logic dc, input logic [17:0] d);
      HOST.xfer(rd, dc, d, q);
      repeat (3) @(posedge clk);
   endtask

   task automatic setMode(input logic [3:0] s, input int n);
      rst <= 1'h1;
      straps <= s;
      enMode <= s[2];
      @(posedge clk);
      HOST.park();
      repeat (n) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      q = {14'h0, serialMode, enableMode, widthCode};
      chk("mode", {14'h0, !s[3], s[3] & s[2], s[1:0]}, q);
      base = wrCount;
      doneBase = doneCount;
   endtask

   initial
   begin
      setMode(4'h8, 20);
      for (int m = 0; m < 8; m++)
      begin
         setMode({1'h1, m[2:0]}, 6);
         mask = masks[m[1:0]];
         xf(1'h0, 1'h0, {10'h3FF, codes[m % 3]});
         chk("cmdWord", {10'h0, codes[m % 3]}, gotWord);
         chk("isCmd", 18'h1, {17'h0, gotCmd});
         repeat (50) @(posedge clk);
         xf(1'h0, 1'h1, 18'h2A5C3);
         chk("dataWord", 18'h2A5C3 & mask, gotWord);
         chk("isData", 18'h0, {17'h0, gotCmd});
         rdWordIsPixel <= 1'h1;
         rdWord <= 18'h35A69;
         xf(1'h1, 1'h1, 18'h0);
         chk("pixel", 18'h35A69 & mask, q & mask);
         chk("pixelOe", ~mask, oeSeen);
         chk("idleOe", 18'h3FFFF, dataOeN);
         rdWordIsPixel <= 1'h0;
         rdWord <= 18'h1C3E7;
         xf(1'h1, 1'h1, 18'h0);
         chk("param", 18'h000E7, q & 18'h000FF);
         chk("paramOe", 18'h3FF00, oeSeen);
         HOST.cutRead();
         repeat (3) @(posedge clk);
         chk("cutDrv", 18'h3FF00, oeSeen);
         chk("cutOe", 18'h3FFFF, dataOeN);
         chk("rdDone", 18'(doneBase + 3), 18'(doneCount));
         useCs <= 1'h0;
         xf(1'h0, 1'h1, 18'h00001);
         useCs <= 1'h1;
         chk("count", 18'(base + 2), 18'(wrCount));
         $display("mode %0d done", m);
      end
      base = wrCount;
      extResetN <= 1'h0;
      xf(1'h0, 1'h1, 18'h00055);
      extResetN <= 1'h1;
      xf(1'h0, 1'h1, 18'h0002A);
      chk("rstDrop", 18'(base + 1), 18'(wrCount));
      chk("afterRst", 18'h0002A, gotWord);
      $display("external reset done");
      setMode(4'h7, 6);
      xf(1'h0, 1'h1, 18'h00033);
      chk("serialWr", 18'(base), 18'(wrCount));
      HOST.pins(1'h1, 1'h0, 1'h1);
      repeat (5) @(posedge clk);
      q = {15'h0, serialClk, serialDcFlag, serialSdaIn};
      chk("route1", 18'h5, q);
      HOST.pins(1'h0, 1'h1, 1'h0);
      repeat (5) @(posedge clk);
      q = {15'h0, serialClk, serialDcFlag, serialSdaIn};
      chk("route0", 18'h2, q);
      sdaOut <= 1'h1;
      sdaOeN <= 1'h0;
      repeat (2) @(posedge clk);
      chk("sdaOe", 18'h3FFFE, dataOeN);
      chk("sdaOut", 18'h00001, dataOut);
      $display("serial done");
      printVerdict();
   end

   initial
   begin
      #100000;
      failCount++;
      $display("BAD watchdog expected done seen hang");
      printVerdict();
   end
endmodule
